// >>> bsc_top.sv
// boundary-scan data register, device reset stage and the two software registers
// assumes an outside tap controller on tck gives instruction and capture/shift/update strobes
`timescale 1ns/1ps
`include "bsc_defines.svh"
module bsc_top (
  // system clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire bsc_pkg::bsc_bus_req_s bus_req,
  output logic [`BSC_DATA_W-1:0] bus_rdata,
  // test link, tck domain
  input wire logic tck,
  input wire bsc_pkg::bsc_tap_s tap,
  output logic tdo,
  // straps and pins
  input wire logic test_if_enable_fuse,
  input wire logic reset_pin_n,
  input wire logic [`BSC_NUM_PINS-1:0] pin_i,
  input wire logic [`BSC_NUM_PINS-1:0] core_out,
  input wire logic [`BSC_NUM_PINS-1:0] core_dir,
  output logic [`BSC_NUM_PINS-1:0] pin_o,
  output logic [`BSC_NUM_PINS-1:0] pin_oe_n,
  // status to the rest of the chip
  output logic test_if_enabled,
  output logic pullup_disable,
  output logic device_reset
);

  // system reset release
  logic rst_s1_reg, rst_sys_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_sys_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sys_n <= rst_s1_reg;
    end
  end

  // tck reset release; the link clock may stop, so release waits for two tck edges
  logic rst_t1_reg, rst_tck_n;
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      rst_t1_reg <= 1'b0;
      rst_tck_n <= 1'b0;
    end else begin
      rst_t1_reg <= 1'b1;
      rst_tck_n <= rst_t1_reg;
    end
  end

  // system-side synchronisers: fuse strap and device reset from tck
  logic fuse_s1_reg, fuse_s2_reg, dres_s1_reg, dres_s2_reg;
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      fuse_s1_reg <= 1'b0;
      fuse_s2_reg <= 1'b0;
      dres_s1_reg <= 1'b0;
      dres_s2_reg <= 1'b0;
    end else begin
      fuse_s1_reg <= test_if_enable_fuse;
      fuse_s2_reg <= fuse_s1_reg;
      dres_s1_reg <= device_reset;
      dres_s2_reg <= dres_s1_reg;
    end
  end

  // software registers
  logic wr_ctrl, wr_stat;
  logic dis_reg, dis_next, pend_reg, pend_next, flag_reg, flag_next, en_reg, en_next;
  logic [2:0] win_reg, win_next;
  logic [`BSC_DATA_W-1:0] rdata_reg, rdata_next;

  always_comb begin
    wr_ctrl = bus_req.wr && (bus_req.addr == `BSC_OFS_MCU_CONTROL);
    wr_stat = bus_req.wr && (bus_req.addr == `BSC_OFS_RESET_SOURCE_STATUS);
    dis_next = dis_reg;
    pend_next = pend_reg;
    win_next = win_reg;
    if (wr_ctrl) begin
      if ((win_reg != `BSC_WINDOW_IDLE) &&
          (bus_req.wdata[`BSC_BIT_TEST_IF_DISABLE] == pend_reg)) begin
        dis_next = pend_reg;
        win_next = `BSC_WINDOW_IDLE;
      end else begin
        // a first or mismatching write only opens a fresh window
        pend_next = bus_req.wdata[`BSC_BIT_TEST_IF_DISABLE];
        win_next = `BSC_TIMED_WINDOW;
      end
    end else if (win_reg != `BSC_WINDOW_IDLE) begin
      win_next = win_reg - 3'h1;
    end
    en_next = !dis_reg && fuse_s2_reg;
    flag_next = flag_reg;
    if (wr_stat && !bus_req.wdata[`BSC_BIT_TEST_RESET_FLAG]) begin
      flag_next = 1'b0;
    end
    if (dres_s2_reg) begin
      flag_next = 1'b1; // set wins over a same-cycle clear
    end
    rdata_next = '0;
    if (bus_req.rd) begin
      if (bus_req.addr == `BSC_OFS_MCU_CONTROL) begin
        rdata_next[`BSC_BIT_TEST_IF_DISABLE] = dis_reg;
      end else if (bus_req.addr == `BSC_OFS_RESET_SOURCE_STATUS) begin
        rdata_next[`BSC_BIT_TEST_RESET_FLAG] = flag_reg;
      end
    end
  end

  // the flag lives on the power-on reset only; device_reset must not clear it
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      dis_reg <= 1'b0;
      pend_reg <= 1'b0;
      win_reg <= `BSC_WINDOW_IDLE;
      flag_reg <= 1'b0;
      en_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      dis_reg <= dis_next;
      pend_reg <= pend_next;
      win_reg <= win_next;
      flag_reg <= flag_next;
      en_reg <= en_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign test_if_enabled = en_reg;

  // tck-side synchronisers: enable level, pin levels, drive state, reset pin
  localparam int SYNC_W = 2 * `BSC_NUM_PINS + 2;
  logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync_in;
  logic [`BSC_NUM_PINS-1:0] drive_en;
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
    end
  end
  assign sync_in = {en_reg, reset_pin_n, drive_en, pin_i};

  logic en_tck, rst_obs;
  logic [`BSC_NUM_PINS-1:0] pin_obs, dir_obs;
  assign pin_obs = sync2_reg[`BSC_NUM_PINS-1:0];
  assign dir_obs = sync2_reg[2*`BSC_NUM_PINS-1:`BSC_NUM_PINS];
  assign rst_obs = sync2_reg[SYNC_W-2];
  assign en_tck = sync2_reg[SYNC_W-1];

  // chain state
  logic [`BSC_CHAIN_LEN-1:0] chain_reg, chain_next, upd_reg, upd_next, cap_vec;
  logic rres_reg, rres_next, tdo_reg, tdo_next, extest;
  bsc_pkg::bsc_dr_sel_e sel;

  // analog cells would be added above bit 56; this device has none
  generate
    for (genvar p = 0; p < `BSC_NUM_PINS; p++) begin : g_pin
      localparam int DPOS = (p < `BSC_PIN_D_BASE) ? `BSC_POS_B0_DATA - 2 * p :
        (p < `BSC_PIN_C_BASE) ? `BSC_POS_D0_DATA - 2 * (p - `BSC_PIN_D_BASE) :
        (p < `BSC_PIN_A_BASE) ? `BSC_POS_C0_DATA - 2 * (p - `BSC_PIN_C_BASE) :
        `BSC_POS_A0_DATA + 2 * (p - `BSC_PIN_A_BASE);
      // data cell captures the synchronised pin level, control cell the synchronised drive enable
      assign cap_vec[DPOS] = pin_obs[p];
      assign cap_vec[DPOS-1] = dir_obs[p];
      assign drive_en[p] = extest ? upd_reg[DPOS-1] : core_dir[p];
      assign pin_o[p] = extest ? upd_reg[DPOS] : core_out[p];
      assign pin_oe_n[p] = !drive_en[p];
    end
  endgenerate
  assign cap_vec[`BSC_POS_RESET_OBSERVE] = rst_obs; // observe only, drives nothing

  always_comb begin
    sel = bsc_pkg::BSC_SEL_NONE;
    if (tap.ir == `BSC_IR_EXTEST || tap.ir == `BSC_IR_SAMPLE_PRELOAD) begin
      sel = bsc_pkg::BSC_SEL_BOUNDARY;
    end else if (tap.ir == `BSC_IR_DEVICE_RESET) begin
      sel = bsc_pkg::BSC_SEL_RESET;
    end
    chain_next = chain_reg;
    upd_next = upd_reg;
    rres_next = rres_reg;
    if (en_tck && sel == bsc_pkg::BSC_SEL_BOUNDARY) begin
      if (tap.capture_dr) begin
        chain_next = cap_vec;
      end else if (tap.shift_dr) begin
        chain_next = {tap.tdi, chain_reg[`BSC_CHAIN_LEN-1:1]}; // lsb out first
      end else if (tap.update_dr) begin
        upd_next = chain_reg;
      end
    end
    if (en_tck && sel == bsc_pkg::BSC_SEL_RESET && tap.shift_dr) begin
      rres_next = tap.tdi;
    end
    tdo_next = 1'b0;
    if (sel == bsc_pkg::BSC_SEL_BOUNDARY) begin
      tdo_next = chain_next[0];
    end else if (sel == bsc_pkg::BSC_SEL_RESET) begin
      tdo_next = rres_next;
    end
  end

  // device_reset only resets the core; these flops stay on power-on reset
  always_ff @(posedge tck or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      chain_reg <= '0;
      upd_reg <= '0;
      rres_reg <= 1'b0;
      tdo_reg <= 1'b0;
    end else begin
      chain_reg <= chain_next;
      upd_reg <= upd_next;
      rres_reg <= rres_next;
      tdo_reg <= tdo_next;
    end
  end

  assign extest = en_tck && (tap.ir == `BSC_IR_EXTEST);
  assign pullup_disable = en_tck && (sel == bsc_pkg::BSC_SEL_BOUNDARY);
  // the stage itself drives reset: no update latch, so it bites mid-shift
  assign device_reset = rres_reg;
  assign tdo = tdo_reg;

  // checks, system domain
  chk_timed_write: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
    $changed(dis_reg) |-> $past(wr_ctrl) && ($past(win_reg) != `BSC_WINDOW_IDLE))
    else $error("disable bit changed without a matching second write");

  chk_single_write: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
    (wr_ctrl && win_reg == `BSC_WINDOW_IDLE) |=> $stable(dis_reg))
    else $error("single write changed the disable bit");

  chk_enable_gate: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
    dis_reg ##1 dis_reg |-> !test_if_enabled)
    else $error("interface enabled while disabled");

  chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
    dres_s2_reg |=> flag_reg)
    else $error("test reset did not set the flag");

  chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
    (wr_stat && !bus_req.wdata[`BSC_BIT_TEST_RESET_FLAG] && !dres_s2_reg) |=> !flag_reg)
    else $error("zero write did not clear the flag");

  chk_flag_hold: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
    (flag_reg && !(wr_stat && !bus_req.wdata[`BSC_BIT_TEST_RESET_FLAG])) |=> flag_reg)
    else $error("test-reset flag dropped without a zero write");

  chk_enable_set: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
    (!dis_reg && fuse_s2_reg) |=> test_if_enabled)
    else $error("interface stayed off with bit clear and fuse set");

  // checks, tck domain
  chk_shift_order: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (en_tck && sel == bsc_pkg::BSC_SEL_BOUNDARY && tap.shift_dr && !tap.capture_dr) |=>
      (chain_reg[`BSC_CHAIN_LEN-1] == $past(tap.tdi)) &&
      (tdo == $past(chain_reg[1])))
    else $error("chain did not advance by one position");

  chk_reset_stage: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (en_tck && sel == bsc_pkg::BSC_SEL_RESET && tap.shift_dr) |=> device_reset == $past(tap.tdi))
    else $error("device reset does not follow the shifted bit");

  chk_observe_cell: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (en_tck && sel == bsc_pkg::BSC_SEL_BOUNDARY && tap.capture_dr) |=>
      chain_reg[`BSC_POS_RESET_OBSERVE] == $past(rst_obs))
    else $error("reset observe cell missed the pin");

  chk_extest_drive: assert property (@(posedge tck) disable iff (!rst_tck_n)
    extest |-> (pin_o[0] == upd_reg[`BSC_POS_B0_DATA]) &&
      (pin_oe_n[0] == !upd_reg[`BSC_POS_B0_DATA-1]) &&
      pullup_disable)
    else $error("first port pin not driven from the top cells");

  // a disabled interface must leave the chain, the update latches and the reset stage alone
  chk_disabled_still: assert property (@(posedge tck) disable iff (!rst_tck_n)
    !en_tck |=> $stable(chain_reg) && $stable(upd_reg) && $stable(rres_reg))
    else $error("tck-side state moved while the interface was disabled");

  chk_reset_select: assert property (@(posedge tck) disable iff (!rst_tck_n)
    !(sel == bsc_pkg::BSC_SEL_RESET && tap.shift_dr) |=> $stable(rres_reg))
    else $error("reset stage moved under another instruction");

  chk_capture_b0: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (en_tck && sel == bsc_pkg::BSC_SEL_BOUNDARY && tap.capture_dr) |=>
      (chain_reg[`BSC_POS_B0_DATA] == $past(pin_obs[0])) &&
      (chain_reg[`BSC_POS_B0_DATA-1] == $past(dir_obs[0])))
    else $error("first pin cells missed pin level or drive state");

  chk_port_d_start: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (en_tck && sel == bsc_pkg::BSC_SEL_BOUNDARY && tap.capture_dr) |=>
      chain_reg[`BSC_POS_D0_DATA] == $past(pin_obs[`BSC_PIN_D_BASE]))
    else $error("second port does not start below the reset cell");

  chk_port_c_start: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (en_tck && sel == bsc_pkg::BSC_SEL_BOUNDARY && tap.capture_dr) |=>
      chain_reg[`BSC_POS_C0_DATA] == $past(pin_obs[`BSC_PIN_C_BASE]))
    else $error("third port does not start at its top cell");

  chk_port_a_end: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (en_tck && sel == bsc_pkg::BSC_SEL_BOUNDARY && tap.capture_dr) |=>
      (chain_reg[`BSC_POS_A0_DATA] == $past(pin_obs[`BSC_PIN_A_BASE])) &&
      (chain_reg[`BSC_POS_A0_DATA-1] == $past(dir_obs[`BSC_PIN_A_BASE])))
    else $error("last port pin zero not at the bottom of the chain");

  chk_preload_quiet: assert property (@(posedge tck) disable iff (!rst_tck_n)
    (tap.ir == `BSC_IR_SAMPLE_PRELOAD) |-> (pin_o == core_out) && (pin_oe_n == ~core_dir))
    else $error("pins follow the latches outside external test");

endmodule // bsc_top

// >>> bsc_defines.svh
// constants for the boundary-scan chain block: offsets, bit positions, opcodes, chain layout
// assumes the test access port state machine and instruction register sit outside
// Overview of operation
// - each pin has data and control cells
// - port B then port D, pin-out order
// - bit 40 observes the reset pin only
// - port C pins 0,1,6,7 only, bits 23-16
// - port A scanned in reversed pin order
// - analog cells sit at the top end
// - interface enabled: disable bit clear, fuse set
// - disable bit changes on two matching writes
// - test reset sets the test-reset flag
// - flag cleared by power-on or zero write
// - reset held while reset stage holds one
// - opcode 0xC selects reset, tap untouched
// - opcodes 0x0, 0x2 select chain, kill pull-ups
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

`define BSC_ADDR_W 4
`define BSC_DATA_W 8
`define BSC_OFS_MCU_CONTROL 4'h0
`define BSC_OFS_RESET_SOURCE_STATUS 4'h1
`define BSC_BIT_TEST_IF_DISABLE 7
`define BSC_BIT_TEST_RESET_FLAG 4
`define BSC_TIMED_WINDOW 3'h4
`define BSC_WINDOW_IDLE 3'h0

`define BSC_CHAIN_LEN 57
`define BSC_NUM_PINS 28
`define BSC_ANALOG_CELLS 0
`define BSC_POS_B0_DATA 56
`define BSC_POS_RESET_OBSERVE 40
`define BSC_POS_D0_DATA 39
`define BSC_POS_C0_DATA 23
`define BSC_POS_A0_DATA 1
`define BSC_PIN_D_BASE 8
`define BSC_PIN_C_BASE 16
`define BSC_PIN_A_BASE 20

`define BSC_IR_W 4
`define BSC_IR_EXTEST 4'h0
`define BSC_IR_SAMPLE_PRELOAD 4'h2
`define BSC_IR_DEVICE_RESET 4'hC

`endif

// >>> bsc_pkg.sv
// types shared by the boundary-scan chain block
// assumes bsc_defines.svh is on the include path
`include "bsc_defines.svh"
package bsc_pkg;
  typedef struct packed {
    logic [`BSC_ADDR_W-1:0] addr;
    logic [`BSC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bsc_bus_req_s;

  typedef struct packed {
    logic [`BSC_IR_W-1:0] ir;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic tdi;
  } bsc_tap_s;

  typedef enum logic [1:0] {
    BSC_SEL_NONE,
    BSC_SEL_BOUNDARY,
    BSC_SEL_RESET
  } bsc_dr_sel_e;
endpackage

// >>> bsc_tap_ctl.sv
// external test controller: drives the tap strobes and runs tck only inside a frame
// assumes bsc_top samples tap and updates tdo on the rising edge of tck
`timescale 1ns/1ps
`include "bsc_defines.svh"
module bsc_tap_ctl (
  // test link
  output logic tck,
  output bsc_pkg::bsc_tap_s tap,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tap = '0;
  end
  // one 6 ns period; the request changes just after the rising edge
  task automatic step(input bsc_pkg::bsc_tap_s v);
    tck = 1'b1;
    tap <= v;
    #3 tck = 1'b0;
    #3;
  endtask
  // idle edges let the enable sync settle, then capture, n shifts and update
  task automatic scan(input logic [3:0] ir, input logic [56:0] din, input int n,
                      output logic [56:0] dout);
    bsc_pkg::bsc_tap_s v;
    v = '0;
    v.ir = ir;
    dout = '0;
    for (int i = 0; i < 4; i++) begin
      v.tdi = ~v.tdi;
      step(v);
    end
    v.capture_dr = 1'b1;
    step(v);
    v.capture_dr = 1'b0;
    v.shift_dr = 1'b1;
    for (int i = 0; i < n; i++) begin
      v.tdi = din[i];
      step(v);
      dout[i] = tdo;
    end
    v.shift_dr = 1'b0;
    v.update_dr = 1'b1;
    step(v);
    v.update_dr = 1'b0;
    // released data line toggles so a stale bit is never mistaken for data
    v.tdi = ~v.tdi;
    step(v);
    step(v);
  endtask
endmodule // bsc_tap_ctl

// >>> bsc_top_tb.sv
// self-checking bench for bsc_top: register port tasks and scans through the tap model
// assumes a 50 MHz clk_sys and the tap model making tck within frames only
`timescale 1ns/1ps
`include "bsc_defines.svh"
module bsc_top_tb;
  logic clk_sys, rst_n, fuse, rst_pin_n, tck, tdo, en, pud, dev_rst;
  bsc_pkg::bsc_bus_req_s bus_req;
  bsc_pkg::bsc_tap_s tap;
  logic [7:0] bus_rdata;
  logic [27:0] pin_i, core_out, core_dir, pin_o, pin_oe_n, po, poe;
  logic [56:0] din, dout, exp, exp2;
  int n_fail = 0;
  int cmp_count = 0;

  bsc_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .tck(tck), .tap(tap), .tdo(tdo), .test_if_enable_fuse(fuse), .reset_pin_n(rst_pin_n),
    .pin_i(pin_i), .core_out(core_out), .core_dir(core_dir), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .test_if_enabled(en), .pullup_disable(pud), .device_reset(dev_rst));
  bsc_tap_ctl u_ctl (.tck(tck), .tap(tap), .tdo(tdo));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    cmp_count++;
    if (got !== want) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] want);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 chk(bus_rdata, want);
  endtask

  // data cell position of pin p; its control cell sits one below
  function automatic int dpos(input int p);
    if (p < 8) return 56 - 2 * p;
    if (p < 16) return 39 - 2 * (p - 8);
    if (p < 20) return 23 - 2 * (p - 16);
    return 2 * (p - 20) + 1;
  endfunction

  task automatic final_report;
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100_000;
    n_fail++;
    final_report;
  end

  initial begin
    rst_n = 1'b0;
    fuse = 1'b1;
    rst_pin_n = 1'b0;
    bus_req = '0;
    pin_i = 28'h5A3_C96E;
    core_out = 28'h0F0_33CC;
    core_dir = 28'h936_A5C1;
    din = 57'h1A5_C3F0_9E6D_2B48;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(en, 1'b1);
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h7, 8'h00);
    exp = '0;
    exp[40] = rst_pin_n;
    exp2 = '0;
    exp2[40] = 1'b1;
    for (int p = 0; p < 28; p++) begin
      exp[dpos(p)] = pin_i[p];
      exp[dpos(p) - 1] = core_dir[p];
      exp2[dpos(p)] = pin_i[p];
      exp2[dpos(p) - 1] = din[dpos(p) - 1];
      po[p] = din[dpos(p)];
      poe[p] = ~din[dpos(p) - 1];
    end
    u_ctl.scan(4'h2, din, 57, dout);
    chk(dout, exp);
    chk(pud, 1'b1);
    chk({pin_oe_n, pin_o}, {~core_dir, core_out});
    // reset pin released; extest captures the latched drive states
    @(posedge clk_sys);
    rst_pin_n <= 1'b1;
    u_ctl.scan(4'h0, din, 57, dout);
    chk(dout, exp2);
    chk(pud, 1'b1);
    chk({pin_oe_n, pin_o}, {poe, po});
    u_ctl.scan(4'hF, din, 0, dout);
    chk({pud, pin_oe_n, pin_o}, {1'b0, ~core_dir, core_out});
    // device reset follows the one-bit stage at once, flag crosses later
    u_ctl.scan(4'hC, 57'h1, 1, dout);
    chk({en, dev_rst}, 2'b11);
    repeat (4) @(posedge clk_sys);
    rd_chk(4'h1, 8'h10);
    wr(4'h1, 8'h00);
    rd_chk(4'h1, 8'h10);
    u_ctl.scan(4'hC, 57'h0, 1, dout);
    chk(dev_rst, 1'b0);
    wr(4'h1, 8'h10);
    rd_chk(4'h1, 8'h10);
    wr(4'h1, 8'h00);
    rd_chk(4'h1, 8'h00);
    // disable bit: single write, then a pair four cycles apart
    wr(4'h0, 8'h80);
    repeat (6) @(posedge clk_sys);
    rd_chk(4'h0, 8'h00);
    wr(4'h0, 8'h80);
    repeat (2) @(posedge clk_sys);
    wr(4'h0, 8'h80);
    rd_chk(4'h0, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk(en, 1'b0);
    u_ctl.scan(4'hC, 57'h1, 1, dout);
    chk(dev_rst, 1'b0);
    wr(4'h0, 8'h00);
    repeat (3) @(posedge clk_sys);
    wr(4'h0, 8'h00);
    rd_chk(4'h0, 8'h80);
    // re-enable only while no scan is running; let the late write's window close first
    repeat (6) @(posedge clk_sys);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h00);
    rd_chk(4'h0, 8'h00);
    repeat (4) @(posedge clk_sys);
    chk(en, 1'b1);
    // power-on reset in mid-run clears a flag left by a test reset
    u_ctl.scan(4'hC, 57'h1, 1, dout);
    repeat (4) @(posedge clk_sys);
    u_ctl.scan(4'hC, 57'h0, 1, dout);
    rd_chk(4'h1, 8'h10);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd_chk(4'h1, 8'h00);
    chk(en, 1'b1);
    @(posedge clk_sys);
    fuse <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(en, 1'b0);
    final_report;
  end
endmodule // bsc_top_tb
